// ===== hdl/ifsb_defs.svh
// constants for the interrupt flag status bank: offsets, bit positions, masks
// Function
// - set flag0 bit 2 on output compare one request; zero until then
// - set flag0 bit 1 on input capture one request; zero means none
// - set flag0 bit 0 on external pin zero request; zero otherwise
// - set flag1 bits 15, 14, 13 on comparators three, two, one
// - set flag1 bit 11 on input change notification request
// - set flag1 bits 6 to 3 on pwm generators four to one
// - set flag1 bit 2 on pwm special event match
// - set flag1 bit 1 for pin two, bit 0 for pin one
// - flag1 bit 12 and bits 10 to 7 read zero, ignore writes
// - set flag2 bits 10 to 5 on conversion pairs five to zero done
`ifndef IFSB_DEFS_SVH
`define IFSB_DEFS_SVH

// ==========================================================
// register byte offsets on the bus
`define IFSB_OFS_FLAG0 8'h00
`define IFSB_OFS_FLAG1 8'h04
`define IFSB_OFS_FLAG2 8'h08

// ==========================================================
// width and reset value of every flag register
`define IFSB_FLAG_W     16
`define IFSB_FLAG_RESET 16'h0000

// ==========================================================
// implemented bits of each register; everything else reads zero
`define IFSB_MASK0 16'h0007
`define IFSB_MASK1 16'hE87F
`define IFSB_MASK2 16'h07E1

// ==========================================================
// flag0 bit positions
`define IFSB_B0_COMPARE_ONE 2
`define IFSB_B0_CAPTURE_ONE 1
`define IFSB_B0_EXT_PIN_ZERO 0

// ==========================================================
// flag1 bit positions
`define IFSB_B1_COMP_THREE 15
`define IFSB_B1_COMP_TWO 14
`define IFSB_B1_COMP_ONE 13
`define IFSB_B1_PIN_CHANGE 11
`define IFSB_B1_PWM_FOUR 6
`define IFSB_B1_PWM_THREE 5
`define IFSB_B1_PWM_TWO 4
`define IFSB_B1_PWM_ONE 3
`define IFSB_B1_PWM_SPECIAL 2
`define IFSB_B1_EXT_PIN_TWO 1
`define IFSB_B1_EXT_PIN_ONE 0

// ==========================================================
// flag2 bit positions
`define IFSB_B2_PAIR_ZERO 5
`define IFSB_B2_COMP_FOUR 0

`endif

// ===== hdl/ifsb_pkg.sv
// types shared by the interrupt flag status bank files
package ifsb_pkg;

  // ==========================================================
  // the three flag registers as seen by the cpu interrupt logic
  typedef struct packed {
    logic [15:0] flag2;
    logic [15:0] flag1;
    logic [15:0] flag0;
  } ifsb_flags_s;

  // ==========================================================
  // register selected by an address
  typedef enum logic [1:0] {
    IFSB_SEL_FLAG0 = 2'h0,
    IFSB_SEL_FLAG1 = 2'h1,
    IFSB_SEL_FLAG2 = 2'h2,
    IFSB_SEL_NONE  = 2'h3
  } ifsb_sel_e;

  // ==========================================================
  // state of one flag register
  typedef struct packed {
    logic [15:0] flags;
  } ifsb_flag_state_s;

  // ==========================================================
  // state of the bus slave
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ifsb_wb_state_s;

  // ==========================================================
  // pin synchroniser and edge detector for the three external pins
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic [2:0] prev;
  } ifsb_pin_state_s;

endpackage : ifsb_pkg

// ===== hdl/ifsb_flag_reg.sv
// one sticky flag register: hardware sets, software writes per byte lane
`timescale 1ns/100ps
`default_nettype none
`include "ifsb_defs.svh"

module ifsb_flag_reg #(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF  // implemented bits
) (
  input  wire logic        clk_i,     // system clock
  input  wire logic        rst_i,     // sync reset, high
  input  wire logic [15:0] set_i,     // hardware set requests
  input  wire logic        wr_i,      // software write strobe
  input  wire logic [1:0]  be_i,      // byte lanes of the write
  input  wire logic [15:0] wdata_i,   // write data
  output logic      [15:0] flags_o    // current flags
);

  ifsb_pkg::ifsb_flag_state_s st;
  ifsb_pkg::ifsb_flag_state_s next_st;
  logic [15:0] lane;

  // ==========================================================
  // write then set: an event in the clearing cycle is not lost
  always_comb begin
    lane = {{8{be_i[1]}}, {8{be_i[0]}}};
    next_st = st;
    if (wr_i) begin
      next_st.flags = (st.flags & ~lane) | (wdata_i & lane);
    end
    next_st.flags = (next_st.flags | set_i) & IMPL_MASK;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.flags <= `IFSB_FLAG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign flags_o = st.flags;

endmodule : ifsb_flag_reg

`default_nettype wire

// ===== hdl/ifsb_wb_slave.sv
// classic wishbone slave handshake with registered read data
`timescale 1ns/100ps
`default_nettype none

module ifsb_wb_slave (
  input  wire logic        clk_i,     // system clock
  input  wire logic        rst_i,     // sync reset, high
  input  wire logic        cyc_i,     // bus cycle
  input  wire logic        stb_i,     // strobe
  input  wire logic        we_i,      // write enable
  input  wire logic [31:0] rdata_i,   // read data from the bank
  output logic             ack_o,     // acknowledge
  output logic      [31:0] dat_o,     // read data, registered
  output logic             wr_o       // write commits this edge
);

  ifsb_pkg::ifsb_wb_state_s st;
  ifsb_pkg::ifsb_wb_state_s next_st;
  logic                     req;

  // ==========================================================
  // answer one cycle after the request; ack drops the cycle after
  always_comb begin
    req = cyc_i & stb_i;
    next_st = st;
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack) begin
      next_st.dat = we_i ? 32'h0000_0000 : rdata_i;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.ack <= 1'b0;
      st.dat <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // write lands on the edge the master sees ack, not before
  assign wr_o  = cyc_i & stb_i & we_i & st.ack;
  assign ack_o = st.ack;
  assign dat_o = st.dat;

endmodule : ifsb_wb_slave

`default_nettype wire

// ===== hdl/ifsb_bank.sv
// interrupt flag status bank: three sticky flag registers on wishbone
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ifsb_defs.svh"

module ifsb_bank #(
  parameter int ADR_W = 8  // byte address width
) (
  input  wire logic             clk_i,            // system clock, 20 MHz
  input  wire logic             rst_i,            // sync reset, high
  // wishbone slave
  input  wire logic             wb_cyc_i,         // bus cycle
  input  wire logic             wb_stb_i,         // strobe
  input  wire logic             wb_we_i,          // write enable
  input  wire logic [ADR_W-1:0] wb_adr_i,         // byte address
  input  wire logic [3:0]       wb_sel_i,         // byte selects
  input  wire logic [31:0]      wb_dat_i,         // write data
  output logic      [31:0]      wb_dat_o,         // read data
  output logic                  wb_ack_o,         // acknowledge
  // on-chip sources, same clock, high while requesting
  input  wire logic             compare_one_i,    // output compare one
  input  wire logic             capture_one_i,    // input capture one
  input  wire logic [3:0]       comparator_i,     // comparators four..one
  input  wire logic             pin_change_i,     // change notification
  input  wire logic [3:0]       pwm_gen_i,        // pwm generators four..one
  input  wire logic             pwm_special_i,    // pwm special event match
  input  wire logic [5:0]       conv_pair_i,      // conversion pairs five..zero
  // external pins, asynchronous, rising edge requests
  input  wire logic [2:0]       ext_pin_i,        // pins two, one, zero
  // to the cpu interrupt logic
  output ifsb_pkg::ifsb_flags_s flags_o           // all flag registers
);

  // ==========================================================
  // address decode, shared by read mux and write strobes
  function automatic ifsb_pkg::ifsb_sel_e decode(input logic [ADR_W-1:0] adr);
    logic [7:0] a;
    a = 8'(adr);
    unique case (a)
      `IFSB_OFS_FLAG0: decode = ifsb_pkg::IFSB_SEL_FLAG0;
      `IFSB_OFS_FLAG1: decode = ifsb_pkg::IFSB_SEL_FLAG1;
      `IFSB_OFS_FLAG2: decode = ifsb_pkg::IFSB_SEL_FLAG2;
      default:         decode = ifsb_pkg::IFSB_SEL_NONE;
    endcase
  endfunction : decode

  ifsb_pkg::ifsb_pin_state_s pin;
  ifsb_pkg::ifsb_pin_state_s next_pin;
  ifsb_pkg::ifsb_sel_e       sel;
  logic [2:0]                pin_rise;
  logic [15:0]               set0;
  logic [15:0]               set1;
  logic [15:0]               set2;
  logic [15:0]               f0;
  logic [15:0]               f1;
  logic [15:0]               f2;
  logic [31:0]               rdata;
  logic                      wr;
  logic [2:0]                wr_reg;

  // ==========================================================
  // pin synchroniser: meta feeds only sync, edges seen on sync/prev
  always_comb begin
    next_pin = pin;
    next_pin.meta = ext_pin_i;
    next_pin.sync = pin.meta;
    next_pin.prev = pin.sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin.meta <= 3'h0;
      pin.sync <= 3'h0;
      pin.prev <= 3'h0;
    end else begin
      pin <= next_pin;
    end
  end

  // a held pin requests once; software may clear while it stays high
  assign pin_rise = pin.sync & ~pin.prev;

  // ==========================================================
  // flag0 set vector
  always_comb begin
    set0 = 16'h0000;
    set0[`IFSB_B0_COMPARE_ONE]  = compare_one_i;
    set0[`IFSB_B0_CAPTURE_ONE]  = capture_one_i;
    set0[`IFSB_B0_EXT_PIN_ZERO] = pin_rise[0];
  end

  // ==========================================================
  // flag1 set vector
  always_comb begin
    set1 = 16'h0000;
    set1[`IFSB_B1_COMP_THREE]  = comparator_i[2];
    set1[`IFSB_B1_COMP_TWO]    = comparator_i[1];
    set1[`IFSB_B1_COMP_ONE]    = comparator_i[0];
    set1[`IFSB_B1_PIN_CHANGE]  = pin_change_i;
    set1[`IFSB_B1_PWM_FOUR]    = pwm_gen_i[3];
    set1[`IFSB_B1_PWM_THREE]   = pwm_gen_i[2];
    set1[`IFSB_B1_PWM_TWO]     = pwm_gen_i[1];
    set1[`IFSB_B1_PWM_ONE]     = pwm_gen_i[0];
    set1[`IFSB_B1_PWM_SPECIAL] = pwm_special_i;
    set1[`IFSB_B1_EXT_PIN_TWO] = pin_rise[2];
    set1[`IFSB_B1_EXT_PIN_ONE] = pin_rise[1];
  end

  // ==========================================================
  // flag2 set vector; pairs occupy six adjacent bits
  always_comb begin
    set2 = 16'h0000;
    set2[`IFSB_B2_PAIR_ZERO +: 6] = conv_pair_i;
    set2[`IFSB_B2_COMP_FOUR]      = comparator_i[3];
  end

  // ==========================================================
  // bus slave and write strobes per register
  assign sel = decode(wb_adr_i);

  ifsb_wb_slave u_wb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc_i   (wb_cyc_i),
    .stb_i   (wb_stb_i),
    .we_i    (wb_we_i),
    .rdata_i (rdata),
    .ack_o   (wb_ack_o),
    .dat_o   (wb_dat_o),
    .wr_o    (wr)
  );

  // unmapped writes are acked and dropped
  always_comb begin
    wr_reg = 3'h0;
    unique case (sel)
      ifsb_pkg::IFSB_SEL_FLAG0: wr_reg[0] = wr;
      ifsb_pkg::IFSB_SEL_FLAG1: wr_reg[1] = wr;
      ifsb_pkg::IFSB_SEL_FLAG2: wr_reg[2] = wr;
      ifsb_pkg::IFSB_SEL_NONE:  wr_reg = 3'h0;
    endcase
  end

  // ==========================================================
  // the three flag registers; unimplemented bits masked inside
  ifsb_flag_reg #(
    .IMPL_MASK (`IFSB_MASK0)
  ) u_flag0 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set0),
    .wr_i    (wr_reg[0]),
    .be_i    (wb_sel_i[1:0]),
    .wdata_i (wb_dat_i[15:0]),
    .flags_o (f0)
  );

  ifsb_flag_reg #(
    .IMPL_MASK (`IFSB_MASK1)
  ) u_flag1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set1),
    .wr_i    (wr_reg[1]),
    .be_i    (wb_sel_i[1:0]),
    .wdata_i (wb_dat_i[15:0]),
    .flags_o (f1)
  );

  ifsb_flag_reg #(
    .IMPL_MASK (`IFSB_MASK2)
  ) u_flag2 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set2),
    .wr_i    (wr_reg[2]),
    .be_i    (wb_sel_i[1:0]),
    .wdata_i (wb_dat_i[15:0]),
    .flags_o (f2)
  );

  // ==========================================================
  // read mux: upper half and unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (sel)
      ifsb_pkg::IFSB_SEL_FLAG0: rdata[15:0] = f0;
      ifsb_pkg::IFSB_SEL_FLAG1: rdata[15:0] = f1;
      ifsb_pkg::IFSB_SEL_FLAG2: rdata[15:0] = f2;
      ifsb_pkg::IFSB_SEL_NONE:  rdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // flags to the cpu interrupt logic come straight from flip-flops
  // one driver for the whole struct; member order is flag2, flag1, flag0
  assign flags_o = {f2, f1, f0};

endmodule : ifsb_bank

`default_nettype wire

// ===== bench/ifsb_src_model.sv
// behavioural model of the peripheral and pin request sources
`timescale 1ns/100ps
`default_nettype none

module ifsb_src_model (
  input  wire logic        clk_i,   // system clock
  input  wire logic [20:0] fire_i,  // bench commands, one per source
  output logic      [20:0] src_o    // request lines toward the bank
);
  // ==========================================================
  // requests leave on the edge after the command, one cycle wide
  always_ff @(posedge clk_i) begin
    src_o <= fire_i;
  end
endmodule : ifsb_src_model
`default_nettype wire

// ===== bench/ifsb_bank_checker.sv
// assertion checker for the interrupt flag status bank
`timescale 1ns/100ps
`default_nettype none
`include "ifsb_defs.svh"

module ifsb_bank_checker #(
  parameter int ADR_W = 8  // byte address width
) (
  input wire logic                  clk_i,          // clock
  input wire logic                  rst_i,          // reset
  input wire logic                  wb_cyc_i,       // bus cycle
  input wire logic                  wb_stb_i,       // strobe
  input wire logic                  wb_we_i,        // write enable
  input wire logic [ADR_W-1:0]      wb_adr_i,       // address
  input wire logic [3:0]            wb_sel_i,       // byte selects
  input wire logic [31:0]           wb_dat_i,       // write data
  input wire logic [31:0]           wb_dat_o,       // read data
  input wire logic                  wb_ack_o,       // acknowledge
  input wire logic                  compare_one_i,  // compare one
  input wire logic                  capture_one_i,  // capture one
  input wire logic [3:0]            comparator_i,   // comparators
  input wire logic                  pin_change_i,   // change notify
  input wire logic [3:0]            pwm_gen_i,      // pwm generators
  input wire logic                  pwm_special_i,  // special event
  input wire logic [5:0]            conv_pair_i,    // conversion pairs
  input wire logic [2:0]            ext_pin_i,      // external pins
  input wire ifsb_pkg::ifsb_flags_s flags_o         // flags
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // each on-chip request shows in its own flag one cycle later; a pin rising edge within one to four cycles
  AST_COMPARE_ONE: assert property (compare_one_i |=> flags_o.flag0[2])
    else $error("compare one flag missing");
  AST_CAPTURE_ONE: assert property (capture_one_i |=> flags_o.flag0[1])
    else $error("capture one flag missing");
  AST_PIN_ZERO: assert property ($rose(ext_pin_i[0]) |-> ##[1:4] flags_o.flag0[0])
    else $error("pin zero flag missing");
  AST_COMPARATORS: assert property (|comparator_i[2:0] |=>
    (flags_o.flag1[15:13] & $past(comparator_i[2:0])) == $past(comparator_i[2:0])) else $error("comparator flag");
  AST_PIN_CHANGE: assert property (pin_change_i |=> flags_o.flag1[11])
    else $error("pin change flag missing");
  AST_PWM_GENS: assert property (|pwm_gen_i |=>
    (flags_o.flag1[6:3] & $past(pwm_gen_i)) == $past(pwm_gen_i)) else $error("pwm flag missing");
  AST_SPECIAL: assert property (pwm_special_i |=> flags_o.flag1[2])
    else $error("special event flag missing");
  AST_PIN_TWO: assert property ($rose(ext_pin_i[2]) |-> ##[1:4] flags_o.flag1[1])
    else $error("pin two flag missing");
  AST_PIN_ONE: assert property ($rose(ext_pin_i[1]) |-> ##[1:4] flags_o.flag1[0])
    else $error("pin one flag missing");
  AST_GAP_ONE: assert property ((flags_o.flag1 & ~`IFSB_MASK1) == 16'h0000)
    else $error("reserved bit set in flag1");
  AST_PAIRS: assert property (|conv_pair_i |=>
    (flags_o.flag2[10:5] & $past(conv_pair_i)) == $past(conv_pair_i)) else $error("pair flag missing");
  // hazard: only a committed write may clear, so everything else keeps bits
  AST_STICKY: assert property (!(wb_ack_o && wb_we_i) |=>
    (flags_o & $past(flags_o)) == $past(flags_o)) else $error("flag lost without write");
  AST_COMP_FOUR: assert property (comparator_i[3] |=> flags_o.flag2[0] &&
    (flags_o.flag2 & ~`IFSB_MASK2) == 16'h0000) else $error("flag2 wrong");
endmodule : ifsb_bank_checker

bind ifsb_bank ifsb_bank_checker #(.ADR_W(ADR_W)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .compare_one_i(compare_one_i), .capture_one_i(capture_one_i),
  .comparator_i(comparator_i), .pin_change_i(pin_change_i), .pwm_gen_i(pwm_gen_i), .pwm_special_i(pwm_special_i),
  .conv_pair_i(conv_pair_i), .ext_pin_i(ext_pin_i), .flags_o(flags_o));
`default_nettype wire

// ===== bench/ifsb_bank_tb.sv
// self-checking bench for the interrupt flag status bank
`timescale 1ns/100ps
`default_nettype none
`include "ifsb_defs.svh"

module ifsb_bank_tb;
  logic                  clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0]            adr;
  logic [3:0]            sel;
  logic [31:0]           wdat, rdat;
  logic [20:0]           fire, src;
  ifsb_pkg::ifsb_flags_s flags;
  logic [15:0]           exp_f [4];
  logic [15:0]           msk [4] = '{`IFSB_MASK0, `IFSB_MASK1, `IFSB_MASK2, 16'h0000};
  // register*16+bit of each source, in fire vector order
  int                    pos [21] = '{2, 1, 29, 30, 31, 32, 27, 19, 20, 21, 22, 18, 37, 38, 39, 40, 41, 42, 0, 16, 17};
  int                    errors, checks_done, cycles;

  ifsb_src_model i_src (.clk_i(clk_i), .fire_i(fire), .src_o(src));
  ifsb_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .compare_one_i(src[0]),
    .capture_one_i(src[1]), .comparator_i(src[5:2]), .pin_change_i(src[6]), .pwm_gen_i(src[10:7]),
    .pwm_special_i(src[11]), .conv_pair_i(src[17:12]), .ext_pin_i(src[20:18]), .flags_o(flags));

  // ==========================================================
  // clock and watchdog; the ceiling is far above the planned run
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      print_verdict();
    end
  end

  task chk(input string what, input logic [47:0] seen, input logic [47:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  // one classic cycle; upper lanes carry noise the slave must ignore
  task xfer(input int r, input logic w, input logic [15:0] d, input logic [1:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= 8'(r * 4);
    sel  <= {2'($urandom), s};
    wdat <= {16'($urandom), d};
    // hold the request until ack is sampled high at a rising edge
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task rd(input int r);
    logic [31:0] q;
    xfer(r, 1'b0, 16'h0000, 2'b00, q);
    chk($sformatf("reg%0d", r), 48'(q), 48'(exp_f[r]));
  endtask : rd

  task wr(input int r, input logic [15:0] d, input logic [1:0] s);
    logic [31:0] q;
    xfer(r, 1'b1, d, s, q);
    for (int b = 0; b < 2; b++) if (s[b]) exp_f[r][b*8+:8] = d[b*8+:8] & msk[r][b*8+:8];
  endtask : wr

  task fire_src(input logic [20:0] v);
    @(posedge clk_i);
    fire <= v;
    @(posedge clk_i);
    fire <= 21'h000000;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 21; i++) if (v[i]) exp_f[pos[i] / 16][pos[i] % 16] = 1'b1;
    chk("flags", flags, {exp_f[2], exp_f[1], exp_f[0]});
  endtask : fire_src

  task print_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    {cyc, stb, we, adr, sel, wdat, fire} = '0;
    rst_i = 1'b1;
    for (int i = 0; i < 4; i++) exp_f[i] = 16'h0000;
    void'($urandom(32'hbaf4));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 4; r++) rd(r);
    $display("test reset done");
    // every source alone, then cleared by software
    for (int k = 0; k < 21; k++) begin
      fire_src(21'h000001 << k);
      rd(pos[k] / 16);
      wr(pos[k] / 16, 16'h0000, 2'b11);
      rd(pos[k] / 16);
    end
    $display("test sources done");
    // software sets per lane; reserved bits stay zero
    for (int r = 0; r < 4; r++) begin
      wr(r, 16'hFFFF, 2'b01);
      rd(r);
      wr(r, 16'hFFFF, 2'b10);
      rd(r);
      wr(r, 16'h0000, 2'b11);
      rd(r);
    end
    $display("test lanes done");
    // random mixes of requests and writes
    for (int n = 0; n < 40; n++) begin
      fire_src(21'($urandom));
      wr($urandom_range(3, 0), 16'($urandom), 2'($urandom));
      for (int r = 0; r < 4; r++) rd(r);
    end
    $display("test random done");
    // reset in mid-run wipes every flag
    fire_src(21'h1FFFFF);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) exp_f[i] = 16'h0000;
    for (int r = 0; r < 4; r++) rd(r);
    $display("test second reset done");
    print_verdict();
  end
endmodule : ifsb_bank_tb
`default_nettype wire
